// File: pkg/serial_port_pkg.sv
/*
  Shared constants and types of the four-mode serial port.
  Assumes an APB master on one 10 MHz clock; register map is word aligned.
*/
package serial_port_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] BUF_OFF = 8'h04;
  localparam logic [7:0] PWR_OFF = 8'h08;
  // serial_control_reg fields
  localparam int MODE_HI_BIT = 7;
  localparam int MODE_LO_BIT = 6;
  localparam int MPC_BIT = 5;
  localparam int REN_BIT = 4;
  localparam int TX_NINTH_BIT = 3;
  localparam int RX_NINTH_BIT = 2;
  localparam int TX_DONE_BIT = 1;
  localparam int RX_DONE_BIT = 0;
  // power_control_reg field
  localparam int BDBL_BIT = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BUF_RST = 8'h00;
  // shift-mode timing in clock periods
  localparam logic [3:0] M0_PER_FAST = 4'h4;
  localparam logic [3:0] M0_PER_SLOW = 4'hC;
  localparam logic [3:0] M0_LEAD_FAST = 4'h1;
  localparam logic [3:0] M0_LEAD_SLOW = 4'h3;
  localparam logic [3:0] M0_LOW_FAST = 4'h2;
  localparam logic [3:0] M0_LOW_SLOW = 4'h6;
  localparam logic [2:0] M0_LAST_BIT = 3'h7;
  // asynchronous framing
  localparam logic [3:0] DIV_LAST = 4'hF;
  localparam logic [3:0] SAMP_A = 4'h7;
  localparam logic [3:0] SAMP_B = 4'h8;
  localparam logic [3:0] SAMP_C = 4'h9;
  localparam logic [3:0] FRAME10 = 4'hA;
  localparam logic [3:0] FRAME11 = 4'hB;

  typedef enum logic [1:0] {
    MODE_SHIFT = 2'h0,
    MODE_TEN = 2'h1,
    MODE_FIX11 = 2'h2,
    MODE_VAR11 = 2'h3
  } mode_t;

  typedef enum logic [2:0] {
    M0_IDLE = 3'b001,
    M0_TX = 3'b010,
    M0_RX = 3'b100
  } m0_state_t;

  typedef struct packed {
    logic rxd_out;
    logic rxd_oe;
    logic txd_out;
  } pins_t;
endpackage : serial_port_pkg

// File: core/serial_port_four_mode.sv
/*
  Four-mode serial port: shift mode plus three asynchronous modes, APB regs.
  Assumes timer_ovf is a one-cycle pulse on clk; rxd_in is an async pin.
*/
`timescale 1ns/1ps
// What this block does
// - shift mode: data on rxd, clock on txd
// - shift frame: eight bits, lsb first, unframed
// - shift clock is clk/12 or clk/4
// - fast: data 1 before fall, low 2
// - slow: data 3 before fall, low 6
// - buffer write starts transmission in every mode
// - shift mode sets tx done after last bit
// - shift receive needs enable and clear rx flag
// - shift mode sets rx done, halts reception
// - ten-bit frame: start, eight data, stop
// - ten-bit rate: overflow over 16 or 32
// - async bits leave at divider rollover
// - tx done at 10th or 11th rollover
// - falling edge resets divider, starts reception
// - vote of samples at states 7,8,9
// - bad start bit aborts the frame
// - load only if rx flag clear, filter passes
// - eleven-bit frame carries programmable ninth bit
// - fixed eleven-bit rate: clk/32 or clk/64
// - variable eleven-bit mode uses overflow rate
// - buffer write goes tx, read gives rx
module serial_port_four_mode (
  input wire logic clk, // 10 MHz system clock
  input wire logic reset, // synchronous, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic timer_ovf, // baud timer overflow pulse
  input wire logic rxd_in, // receive line level
  output serial_port_pkg::pins_t pins // rxd drive, rxd enable, txd
);
  logic [7:0] ctrl_q, rbuf_q;
  logic bdbl_q, pready_q, pslverr_q;
  logic [31:0] prdata_q;
  serial_port_pkg::pins_t pins_q;
  logic rx_s1_q, rx_s2_q, rx_prev_q;
  logic [1:0] pre_q;
  logic tick;
  logic [3:0] tx_div_q, tx_cnt_q;
  logic tx_busy_q, tx_line_q;
  logic [10:0] tx_sh_q;
  logic rx_busy_q;
  logic [3:0] rx_div_q, rx_bit_q;
  logic [1:0] rx_samp_q;
  logic [8:0] rx_sh_q;
  serial_port_pkg::m0_state_t m0_state_q;
  logic [3:0] m0_ph_q;
  logic [2:0] m0_bit_q;
  logic [7:0] m0_sh_q;
  logic m0_sclk_q, m0_dat_q;
  serial_port_pkg::mode_t mode;
  logic mpc, ren, ten_bit, m0, acc, wr_en, wr_ctrl, wr_buf;
  logic [3:0] per, fall_ph, rise_ph, frame_bits;
  logic tx_roll, ti_set, ri_set, ri_load, rx_vote_en, rx_v, rx_fin, rx_fall;
  logic [7:0] ri_data;
  logic ri_ninth;

  function automatic logic vote3(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction : vote3

  assign mode = serial_port_pkg::mode_t'({ctrl_q[serial_port_pkg::MODE_HI_BIT],
                                          ctrl_q[serial_port_pkg::MODE_LO_BIT]});
  assign mpc = ctrl_q[serial_port_pkg::MPC_BIT];
  assign ren = ctrl_q[serial_port_pkg::REN_BIT];
  assign m0 = (mode == serial_port_pkg::MODE_SHIFT);
  assign ten_bit = (mode == serial_port_pkg::MODE_TEN);
  assign frame_bits = ten_bit ? serial_port_pkg::FRAME10 : serial_port_pkg::FRAME11;
  assign per = mpc ? serial_port_pkg::M0_PER_FAST : serial_port_pkg::M0_PER_SLOW;
  assign fall_ph = mpc ? serial_port_pkg::M0_LEAD_FAST : serial_port_pkg::M0_LEAD_SLOW;
  assign rise_ph = fall_ph + (mpc ? serial_port_pkg::M0_LOW_FAST : serial_port_pkg::M0_LOW_SLOW);

  // apb: one wait state, ready and data both registered
  assign acc = psel & penable & pready_q;
  assign wr_en = acc & pwrite & ~pslverr_q;
  assign wr_ctrl = wr_en & (paddr == serial_port_pkg::CTRL_OFF);
  assign wr_buf = wr_en & (paddr == serial_port_pkg::BUF_OFF);

  always_ff @(posedge clk) begin
    if (reset) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      pslverr_q <= 1'b0;
      if (psel & penable & ~pready_q) begin
        prdata_q <= 32'h0000_0000;
        case (paddr)
          serial_port_pkg::CTRL_OFF: prdata_q[7:0] <= ctrl_q;
          serial_port_pkg::BUF_OFF: prdata_q[7:0] <= rbuf_q;
          serial_port_pkg::PWR_OFF: prdata_q[serial_port_pkg::BDBL_BIT] <= bdbl_q;
          default: pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  // control register; hardware set beats a software clear
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= serial_port_pkg::CTRL_RST;
      bdbl_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q[7:2] <= pwdata[7:2];
      end
      if (ri_load) begin
        ctrl_q[serial_port_pkg::RX_NINTH_BIT] <= ri_ninth;
      end
      ctrl_q[serial_port_pkg::TX_DONE_BIT] <= ti_set |
        (wr_ctrl ? pwdata[serial_port_pkg::TX_DONE_BIT] : ctrl_q[serial_port_pkg::TX_DONE_BIT]);
      ctrl_q[serial_port_pkg::RX_DONE_BIT] <= ri_set |
        (wr_ctrl ? pwdata[serial_port_pkg::RX_DONE_BIT] : ctrl_q[serial_port_pkg::RX_DONE_BIT]);
      if (wr_en & (paddr == serial_port_pkg::PWR_OFF)) begin
        bdbl_q <= pwdata[serial_port_pkg::BDBL_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rbuf_q <= serial_port_pkg::BUF_RST;
    end else if (ri_set) begin
      rbuf_q <= ri_data;
    end
  end

  // receive pin synchroniser plus one stage for edge finding
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_s1_q <= rxd_in;
      rx_s2_q <= rx_s1_q;
      rx_prev_q <= rx_s2_q;
    end
  end

  // 16x tick: mode 2 from clk, modes 1 and 3 from timer overflow
  always_ff @(posedge clk) begin
    if (reset) begin
      pre_q <= 2'h0;
    end else if ((mode == serial_port_pkg::MODE_FIX11) | timer_ovf) begin
      pre_q <= pre_q + 2'h1;
    end
  end

  always_comb begin
    if (mode == serial_port_pkg::MODE_FIX11) begin
      tick = bdbl_q ? pre_q[0] : (pre_q == 2'h3);
    end else begin
      tick = timer_ovf & (bdbl_q | pre_q[0]);
    end
  end

  // asynchronous transmitter
  assign tx_roll = tick & (tx_div_q == serial_port_pkg::DIV_LAST);
  assign ti_set = (tx_busy_q & tx_roll & (tx_cnt_q == frame_bits - 4'h1)) |
                  ((m0_state_q == serial_port_pkg::M0_TX) & (m0_ph_q == per - 4'h1) &
                   (m0_bit_q == serial_port_pkg::M0_LAST_BIT));

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_div_q <= 4'h0;
    end else if (tick) begin
      tx_div_q <= tx_div_q + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q <= 4'h0;
      tx_sh_q <= 11'h7FF;
      tx_line_q <= 1'b1;
    end else if (wr_buf & ~m0) begin
      // frame waits for the divider, not the write
      tx_busy_q <= 1'b1;
      tx_cnt_q <= 4'h0;
      tx_sh_q <= {1'b1, ten_bit | ctrl_q[serial_port_pkg::TX_NINTH_BIT], pwdata[7:0], 1'b0};
    end else if (tx_busy_q & tx_roll) begin
      tx_line_q <= tx_sh_q[0];
      tx_sh_q <= {1'b1, tx_sh_q[10:1]};
      tx_cnt_q <= tx_cnt_q + 4'h1;
      tx_busy_q <= ~ti_set;
    end
  end

  // asynchronous receiver
  assign rx_fall = rx_prev_q & ~rx_s2_q;
  assign rx_vote_en = rx_busy_q & tick & (rx_div_q == serial_port_pkg::SAMP_C);
  assign rx_v = vote3(rx_samp_q[1], rx_samp_q[0], rx_s2_q);
  assign rx_fin = rx_vote_en & (rx_bit_q == frame_bits - 4'h1);

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_busy_q <= 1'b0;
      rx_div_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_samp_q <= 2'h0;
      rx_sh_q <= 9'h000;
    end else if (m0 | ~ren) begin
      rx_busy_q <= 1'b0;
    end else if (~rx_busy_q) begin
      if (rx_fall) begin
        rx_busy_q <= 1'b1;
        rx_div_q <= 4'h0;
        rx_bit_q <= 4'h0;
      end
    end else begin
      if (tick) begin
        rx_div_q <= rx_div_q + 4'h1;
      end
      if (tick & ((rx_div_q == serial_port_pkg::SAMP_A) |
                  (rx_div_q == serial_port_pkg::SAMP_B))) begin
        rx_samp_q <= {rx_samp_q[0], rx_s2_q};
      end
      if (rx_vote_en) begin
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0) begin
          rx_busy_q <= ~rx_v;
        end else if (rx_fin) begin
          // back to edge hunting from mid stop bit
          rx_busy_q <= 1'b0;
        end else begin
          rx_sh_q <= {rx_v, rx_sh_q[8:1]};
        end
      end
    end
  end

  // shift-mode engine, half duplex
  always_ff @(posedge clk) begin
    if (reset) begin
      m0_state_q <= serial_port_pkg::M0_IDLE;
      m0_ph_q <= 4'h0;
      m0_bit_q <= 3'h0;
      m0_sh_q <= 8'h00;
      m0_sclk_q <= 1'b1;
      m0_dat_q <= 1'b1;
    end else begin
      case (m0_state_q)
        serial_port_pkg::M0_IDLE: begin
          m0_ph_q <= 4'h0;
          m0_bit_q <= 3'h0;
          m0_sclk_q <= 1'b1;
          if (m0 & wr_buf) begin
            m0_state_q <= serial_port_pkg::M0_TX;
            m0_sh_q <= {1'b1, pwdata[7:1]};
            m0_dat_q <= pwdata[0];
          end else if (m0 & ren & ~ctrl_q[serial_port_pkg::RX_DONE_BIT]) begin
            m0_state_q <= serial_port_pkg::M0_RX;
          end
        end
        serial_port_pkg::M0_TX, serial_port_pkg::M0_RX: begin
          m0_ph_q <= (m0_ph_q == per - 4'h1) ? 4'h0 : m0_ph_q + 4'h1;
          if (m0_ph_q == fall_ph - 4'h1) begin
            m0_sclk_q <= 1'b0;
          end
          if (m0_ph_q == rise_ph - 4'h1) begin
            m0_sclk_q <= 1'b1;
            if (m0_state_q == serial_port_pkg::M0_RX) begin
              // peer moved data at the fall
              m0_sh_q <= {rx_s2_q, m0_sh_q[7:1]};
            end
          end
          if (m0_ph_q == per - 4'h1) begin
            m0_bit_q <= m0_bit_q + 3'h1;
            if (m0_bit_q == serial_port_pkg::M0_LAST_BIT) begin
              m0_state_q <= serial_port_pkg::M0_IDLE;
            end else if (m0_state_q == serial_port_pkg::M0_TX) begin
              m0_dat_q <= m0_sh_q[0];
              m0_sh_q <= {1'b1, m0_sh_q[7:1]};
            end
          end
        end
        default: m0_state_q <= serial_port_pkg::M0_IDLE;
      endcase
    end
  end

  // completion of a received frame in either engine
  always_comb begin
    ri_load = 1'b0;
    ri_data = m0_sh_q;
    ri_ninth = 1'b0;
    if ((m0_state_q == serial_port_pkg::M0_RX) & (m0_ph_q == per - 4'h1) &
        (m0_bit_q == serial_port_pkg::M0_LAST_BIT)) begin
      ri_load = 1'b1;
    end else if (rx_fin) begin
      ri_data = ten_bit ? rx_sh_q[8:1] : rx_sh_q[7:0];
      ri_ninth = ten_bit ? rx_v : rx_sh_q[8];
      ri_load = ~ctrl_q[serial_port_pkg::RX_DONE_BIT] & (~mpc | ri_ninth) &
                ~(wr_ctrl & pwdata[serial_port_pkg::RX_DONE_BIT]);
    end
  end
  assign ri_set = ri_load;

  // single output stage keeps shift data and clock aligned
  always_ff @(posedge clk) begin
    if (reset) begin
      pins_q <= '{rxd_out: 1'b1, rxd_oe: 1'b0, txd_out: 1'b1};
    end else begin
      pins_q.rxd_out <= m0_dat_q;
      pins_q.rxd_oe <= (m0_state_q == serial_port_pkg::M0_TX);
      pins_q.txd_out <= m0 ? m0_sclk_q : tx_line_q;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pins = pins_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence fast_low_s;
    (!pins_q.txd_out)[*2] ##1 pins_q.txd_out;
  endsequence
  sequence slow_low_s;
    (!pins_q.txd_out)[*6] ##1 pins_q.txd_out;
  endsequence

  drive_shift_a: assert property (pins_q.rxd_oe |-> $past(m0))
    else $error("rxd driven outside shift mode");
  fast_low_a: assert property ($fell(pins_q.txd_out) && m0 && mpc && !wr_ctrl
                               |-> fast_low_s)
    else $error("fast shift clock low time wrong");
  slow_low_a: assert property ($fell(pins_q.txd_out) && m0 && !mpc && !wr_ctrl
                               |-> slow_low_s)
    else $error("slow shift clock low time wrong");
  shift_rate_a: assert property ((m0_state_q != serial_port_pkg::M0_IDLE) && m0_ph_q == 4'h0
                                 && !mpc && !wr_ctrl |-> ##12 (m0_ph_q == 4'h0))
    else $error("shift bit period not twelve clocks");
  tx_roll_a: assert property ($changed(tx_line_q) |-> $past(tx_roll))
    else $error("tx bit moved off a rollover");
  tx_stop_a: assert property (ti_set && !m0 |-> ##2 pins_q.txd_out)
    else $error("tx done not at stop bit");
  rx_start_a: assert property (!rx_busy_q && rx_fall && ren && !m0 |=>
                               rx_busy_q && rx_div_q == 4'h0)
    else $error("falling edge did not start reception");
  bad_start_a: assert property (rx_vote_en && rx_bit_q == 4'h0 && rx_v && !m0 && ren
                                |=> !rx_busy_q)
    else $error("bad start bit not aborted");
  rx_hold_a: assert property (rx_fin && ctrl_q[serial_port_pkg::RX_DONE_BIT] && !m0
                              |=> $stable(rbuf_q))
    else $error("buffer overwritten while rx flag set");
  shift_halt_a: assert property (m0_state_q == serial_port_pkg::M0_IDLE &&
                                 ctrl_q[serial_port_pkg::RX_DONE_BIT] && !wr_buf
                                 |=> m0_state_q != serial_port_pkg::M0_RX)
    else $error("shift reception with rx flag set");
  buf_read_a: assert property (psel && penable && !pready_q && !pwrite &&
                               paddr == serial_port_pkg::BUF_OFF
                               |=> prdata_q[7:0] == $past(rbuf_q))
    else $error("buffer read not from receive side");
endmodule : serial_port_four_mode

// File: verification/serial_peer.sv
/*
  Far-side model of the serial port: a shift-register peer for shift mode
  and an asynchronous transmitter/receiver for the framed modes.
  Assumes the bench resolves rxd from both drivers with a pull-up to 1.
*/
`timescale 1ns/1ps
module serial_peer (
  input wire logic clk, // system clock, times the line
  input wire logic txd, // device serial out or shift clock
  input wire logic line, // resolved rxd level
  output logic dout, // level this model puts on rxd
  output logic oe // high while this model drives rxd
);
  initial begin
    dout = 1'b1;
    oe = 1'b0;
  end

  // latches on shift clock rise; figures are clk periods seen at the pins
  task automatic shift_capture(output logic [7:0] d, output int low_c, output int lead_c,
      output int per_c);
    int n = 0, t = 0, t_chg = 0, t_fall = 0, t_rise = 0;
    logic ptx = txd, pd = line;
    while (n < 8 && t < 3000) begin
      @(posedge clk);
      t++;
      if (line !== pd) t_chg = t;
      if (ptx && !txd) begin
        t_fall = t;
        lead_c = t - t_chg;
      end
      if (!ptx && txd) begin
        d[n] = line;
        low_c = t - t_fall;
        if (n > 0) per_c = t - t_rise;
        t_rise = t;
        n++;
      end
      ptx = txd;
      pd = line;
    end
  endtask : shift_capture

  // new bit only after each fall, so it is stable well before the next rise
  task automatic shift_send(input logic [7:0] d);
    int n = 0, r = 0, t = 0;
    logic ptx = txd;
    dout <= d[0];
    oe <= 1'b1;
    while (r < 8 && t < 3000) begin
      @(posedge clk);
      t++;
      if (ptx && !txd) begin
        dout <= d[n[2:0]];
        n++;
      end
      if (!ptx && txd) r++;
      ptx = txd;
    end
    oe <= 1'b0;
  endtask : shift_send

  task automatic async_send(input logic [10:0] b, input int nb, input int bc);
    oe <= 1'b1;
    for (int i = 0; i < nb; i++) begin
      dout <= b[i];
      repeat (bc) @(posedge clk);
    end
    oe <= 1'b0;
    dout <= 1'b1;
  endtask : async_send

  // samples mid-bit after the start edge; unused high bits read 1
  task automatic async_capture(input int nb, input int bc, output logic [10:0] b);
    int t = 0;
    b = '1;
    while (txd !== 1'b0 && t < 20000) begin
      @(posedge clk);
      t++;
    end
    repeat (bc / 2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      b[i] = txd;
      repeat (bc) @(posedge clk);
    end
  endtask : async_capture
endmodule : serial_peer

// File: verification/serial_port_four_mode_test.sv
/*
  Self-checking bench of the four-mode serial port over APB.
  Assumes the peer model beside it and a timer overflow every 8 clocks.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
  end \
end
module serial_port_four_mode_test;
  logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic timer_ovf = 1'b0, er, rxd_line, peer_out, peer_oe, pready, pslverr;
  logic [7:0] paddr = 8'h00, cap;
  logic [2:0] ovf_cnt = 3'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [10:0] fr;
  serial_port_pkg::pins_t pins;
  int errors = 0, n_checks = 0, low, lead, per, falls;
  logic [7:0] tsc [3] = '{8'h40, 8'h88, 8'hC0};
  int tbc [3] = '{128, 64, 128};
  logic [10:0] tef [3] = '{{2'h3, 8'hC5, 1'h0}, {2'h3, 8'h3A, 1'h0}, {2'h2, 8'h96, 1'h0}};
  logic [7:0] rsc [5] = '{8'h50, 8'h90, 8'hF0, 8'hF0, 8'hF5};
  logic [7:0] rxs [5] = '{8'h55, 8'h95, 8'hF0, 8'hF5, 8'hF5};
  logic [7:0] rxb [5] = '{8'h69, 8'hA7, 8'hA7, 8'h33, 8'h33};
  int rbc [5] = '{128, 32, 128, 128, 128};
  logic [10:0] rfr [5] = '{{2'h3, 8'h69, 1'h0}, {2'h3, 8'hA7, 1'h0}, {2'h2, 8'h5E, 1'h0},
    {2'h3, 8'h33, 1'h0}, {2'h3, 8'h11, 1'h0}};

  always #50 clk = ~clk;

  always @(posedge clk) begin
    ovf_cnt <= ovf_cnt + 3'h1;
    timer_ovf <= (ovf_cnt == 3'h7);
  end

  // rxd has a pull-up: released line reads 1
  assign rxd_line = pins.rxd_oe ? pins.rxd_out : (peer_oe ? peer_out : 1'b1);

  serial_port_four_mode DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_ovf(timer_ovf), .rxd_in(rxd_line), .pins(pins));

  serial_peer peer (.clk(clk), .txd(pins.txd_out), .line(rxd_line), .dout(peer_out),
    .oe(peer_oe));

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    rd = prdata;
    er = pslverr;
    `CHK("pready", 1'b1, pready)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(nm, {24'h0, e}, rd)
  endtask : rchk

  task automatic count_falls(input int n, output int f);
    logic p = pins.txd_out;
    f = 0;
    repeat (n) begin
      @(posedge clk);
      if (p && !pins.txd_out) f++;
      p = pins.txd_out;
    end
  endtask : count_falls

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    `CHK("txd idle", 1'b1, pins.txd_out)
    `CHK("rxd oe idle", 1'b0, pins.rxd_oe)
    rchk("ctrl rst", serial_port_pkg::CTRL_OFF, serial_port_pkg::CTRL_RST);
    rchk("buf rst", serial_port_pkg::BUF_OFF, serial_port_pkg::BUF_RST);
    apb(1'b0, 8'h0C, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, serial_port_pkg::CTRL_OFF, s ? 32'h20 : 32'h00);
      fork
        apb(1'b1, serial_port_pkg::BUF_OFF, 32'hAA);
        peer.shift_capture(cap, low, lead, per);
      join
      `CHK("m0 tx byte", 8'hAA, cap)
      `CHK("m0 period", s ? 4 : 12, per)
      `CHK("m0 low", s ? 2 : 6, low)
      `CHK("m0 lead", s ? 1 : 3, lead)
      repeat (20) @(posedge clk);
      rchk("m0 tx done", serial_port_pkg::CTRL_OFF, s ? 8'h22 : 8'h02);
    end
    rchk("buf is rx side", serial_port_pkg::BUF_OFF, 8'h00);
    fork
      peer.shift_send(8'h4B);
      apb(1'b1, serial_port_pkg::CTRL_OFF, 32'h10);
    join
    repeat (20) @(posedge clk);
    rchk("m0 rx done", serial_port_pkg::CTRL_OFF, 8'h11);
    rchk("m0 rx byte", serial_port_pkg::BUF_OFF, 8'h4B);
    count_falls(100, falls);
    `CHK("m0 rx halted", 0, falls)
    apb(1'b1, serial_port_pkg::CTRL_OFF, 32'h10);
    count_falls(60, falls);
    `CHK("m0 rx restart", 1'b1, falls > 0)
    repeat (150) @(posedge clk);
    rchk("m0 rx idle line", serial_port_pkg::BUF_OFF, 8'hFF);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, serial_port_pkg::PWR_OFF, {24'h0, (k == 1) ? 8'h00 : 8'h80});
      apb(1'b1, serial_port_pkg::CTRL_OFF, {24'h0, tsc[k]});
      fork
        peer.async_capture((k == 0) ? 10 : 11, tbc[k], fr);
        begin
          apb(1'b1, serial_port_pkg::BUF_OFF, {24'h0, tef[k][8:1]});
          rchk("tx busy", serial_port_pkg::CTRL_OFF, tsc[k]);
        end
      join
      `CHK("async frame", tef[k], fr)
      rchk("async tx done", serial_port_pkg::CTRL_OFF, tsc[k] | 8'h02);
    end
    apb(1'b1, serial_port_pkg::PWR_OFF, 32'h80);
    for (int k = 0; k < 5; k++) begin
      if (k != 4) apb(1'b1, serial_port_pkg::CTRL_OFF, {24'h0, rsc[k]});
      peer.async_send(11'h0, 1, 4);
      repeat (12 * rbc[k]) @(posedge clk);
      peer.async_send(rfr[k], (k == 0) ? 10 : 11, rbc[k]);
      repeat (20) @(posedge clk);
      rchk("rx flags", serial_port_pkg::CTRL_OFF, rxs[k]);
      rchk("rx data", serial_port_pkg::BUF_OFF, rxb[k]);
    end
    final_report();
  end

  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    final_report();
  end
endmodule : serial_port_four_mode_test
